// ===== odb_pkg.sv
`default_nettype none
package odb_pkg;
	// Register offsets on page 1
	localparam logic [7:0] ADDR_SPK_CTRL = 8'h2A;
	localparam logic [7:0] ADDR_RSVD_2B = 8'h2B;
	localparam logic [7:0] ADDR_HP_CTRL = 8'h2C;
	localparam logic [7:0] ADDR_RSVD_2D = 8'h2D;
	localparam logic [7:0] ADDR_BIAS_PD = 8'h2E;
	// Field positions
	localparam int SPK_UNMUTE_BIT = 2;
	localparam int SPK_GAIN_LO = 3;
	localparam int SPK_DONE_BIT = 0;
	localparam int HP_DEB_LO = 5;
	localparam int HP_PERF_LO = 3;
	localparam int HP_LINEOUT_BIT = 2;
	localparam int BIAS_PD_BIT = 7;
	localparam int BIAS_FORCE_BIT = 3;
	localparam int BIAS_LVL_LO = 0;
	// Reset values and writable masks
	localparam logic [7:0] SPK_RESET = 8'h00;
	localparam logic [7:0] HP_RESET = 8'h00;
	localparam logic [7:0] BIAS_RESET = 8'h00;
	localparam logic [7:0] SPK_WMASK = 8'h1C;
	localparam logic [7:0] HP_WMASK = 8'hFC;
	localparam logic [7:0] BIAS_WMASK = 8'h8B;
	localparam logic [1:0] PERF_RESERVED = 2'h2;
	// Debounce timebase: 1 MHz tick from the 40 MHz clock, period 8 us per code 001
	localparam int CLK_MHZ = 40;
	localparam int TICK_US = 1;
	localparam int TICK_CYC = CLK_MHZ * TICK_US;
	// Oscillator source: nominal 8.2 MHz, unit tick is 8 oscillator periods
	localparam int OSC_DIV = 8;
	localparam int DEB_SAMPLES = 8;
	// Cycles of the gain ramp taken per step
	localparam int GAIN_STEP_CYC = 4;
endpackage
`default_nettype wire

// ===== odb_debounce.sv
`default_nettype none
// Short-circuit debouncer; sampling period is one eighth of the selected duration
module odb_debounce (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Control
	input wire logic [2:0] code_in,
	input wire logic use_osc_in,
	input wire logic osc_tick_in,
	input wire logic raw_in,
	// Result
	output logic short_out
);
	logic [7:0] pre_cnt;
	logic [3:0] hits;
	logic base_tick;
	logic samp_tick;
	logic [6:0] samp_div;
	logic [6:0] samp_len;

	// Base tick: 1 us from the main clock or one oscillator unit
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			pre_cnt <= 8'h00;
		else if (use_osc_in)
			pre_cnt <= 8'h00;
		else if (pre_cnt == 8'(odb_pkg::TICK_CYC - 1))
			pre_cnt <= 8'h00;
		else
			pre_cnt <= pre_cnt + 8'h01;
	end
	assign base_tick = use_osc_in ? osc_tick_in : (pre_cnt == 8'(odb_pkg::TICK_CYC - 1));

	// Sample period in base ticks: code 001 gives 1, doubling per code
	assign samp_len = (code_in == 3'h0) ? 7'h01 : 7'(7'h01 << (code_in - 3'h1));
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			samp_div <= 7'h00;
		else if (base_tick)
			samp_div <= (samp_div + 7'h01 >= samp_len) ? 7'h00 : samp_div + 7'h01;
	end
	assign samp_tick = base_tick && (samp_div + 7'h01 >= samp_len);

	// Count eight consecutive asserted samples before reporting
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			hits <= 4'h0;
			short_out <= 1'b0;
		end
		else if (!raw_in)
		begin
			hits <= 4'h0;
			short_out <= 1'b0;
		end
		else if (code_in == 3'h0)
			short_out <= 1'b1;
		else if (samp_tick)
		begin
			if (hits == 4'(odb_pkg::DEB_SAMPLES - 1))
				short_out <= 1'b1;
			else
				hits <= hits + 4'h1;
		end
	end

	chk_zero_code_fast: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(raw_in && code_in == 3'h0) |=> short_out)
		else $error("zero debounce code did not report at once");
	chk_short_drops: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!raw_in |=> !short_out)
		else $error("short flag held without raw detection");
endmodule
`default_nettype wire

// ===== odb_regs.sv
`default_nettype none
// Overview of operation
// - Speaker driver stays muted until unmute bit is set; reset keeps it muted.
// - Read-only done bit is 0 while a speaker gain change is pending.
// - Three-bit debounce code: 0 us, then 8 us doubling per step.
// - Oscillator timebase gives about 7.8 us upward, doubling per step.
// - Debounce sampling period is one eighth of the selected duration.
// - Two-bit DAC performance mode; code 10 reserved, never written.
// - Lineout bit: 0 headphone driver, 1 lineout driver, reset 0.
// - Power-down bit 1 enables software power-down; reset 0.
// - Bias off with detection on and no headset unless force bit set.
// - Bias level code: off, 2 V, 2.5 V, analog supply rail.
// - Speaker output stage gain code selects 6, 12, 18, 24 dB.
module odb_regs (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Register access from the serial control slave
	input wire logic wr_en_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] rdata_out,
	// Status inputs from analog and detection
	input wire logic osc_tick_in,
	input wire logic use_osc_in,
	input wire logic short_raw_in,
	input wire logic hs_detect_en_in,
	input wire logic hs_present_in,
	// Controls to the analog blocks
	output logic spk_unmute_out,
	output logic [1:0] spk_gain_out,
	output logic [1:0] dac_perf_out,
	output logic lineout_out,
	output logic sw_pd_out,
	output logic [1:0] bias_level_out,
	output logic short_det_out
);
	logic [7:0] spk_reg;
	logic [7:0] hp_reg;
	logic [7:0] bias_reg;
	logic [1:0] gain_applied;
	logic [2:0] step_cnt;
	logic gain_done;
	logic bias_on;
	logic short_int;
	logic [7:0] next_rdata;
	logic [3:0] ramp_age;

	// Register writes; reserved bits are masked so they always read zero
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			spk_reg <= odb_pkg::SPK_RESET;
			hp_reg <= odb_pkg::HP_RESET;
			bias_reg <= odb_pkg::BIAS_RESET;
		end
		else if (wr_en_in)
		begin
			if (addr_in == odb_pkg::ADDR_SPK_CTRL)
				spk_reg <= wdata_in & odb_pkg::SPK_WMASK;
			else if (addr_in == odb_pkg::ADDR_HP_CTRL)
			begin
				// A reserved performance code is refused; other fields still update
				if (wdata_in[odb_pkg::HP_PERF_LO +: 2] == odb_pkg::PERF_RESERVED)
					hp_reg <= (wdata_in & odb_pkg::HP_WMASK & 8'hE7) | (hp_reg & 8'h18);
				else
					hp_reg <= wdata_in & odb_pkg::HP_WMASK;
			end
			else if (addr_in == odb_pkg::ADDR_BIAS_PD)
				bias_reg <= wdata_in & odb_pkg::BIAS_WMASK;
			// Writes to 0x2B and 0x2D are dropped
		end
	end

	// Gain ramp: applied gain steps toward the programmed code
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			gain_applied <= 2'h0;
			step_cnt <= 3'h0;
		end
		else if (gain_applied == spk_reg[odb_pkg::SPK_GAIN_LO +: 2])
			step_cnt <= 3'h0;
		else if (step_cnt == 3'(odb_pkg::GAIN_STEP_CYC - 1))
		begin
			step_cnt <= 3'h0;
			if (gain_applied < spk_reg[odb_pkg::SPK_GAIN_LO +: 2])
				gain_applied <= gain_applied + 2'h1;
			else
				gain_applied <= gain_applied - 2'h1;
		end
		else
			step_cnt <= step_cnt + 3'h1;
	end
	assign gain_done = (gain_applied == spk_reg[odb_pkg::SPK_GAIN_LO +: 2]);

	// Bias gating by headset presence
	assign bias_on = bias_reg[odb_pkg::BIAS_FORCE_BIT] || !hs_detect_en_in || hs_present_in;

	// Debounced short detection, timebase selected by input
	odb_debounce u_deb (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.code_in(hp_reg[odb_pkg::HP_DEB_LO +: 3]),
		.use_osc_in(use_osc_in),
		.osc_tick_in(osc_tick_in),
		.raw_in(short_raw_in),
		.short_out(short_int)
	);

	// Read mux; reserved registers read zero
	always_comb
	begin
		if (addr_in == odb_pkg::ADDR_SPK_CTRL)
			next_rdata = spk_reg | {7'h00, gain_done};
		else if (addr_in == odb_pkg::ADDR_HP_CTRL)
			next_rdata = hp_reg;
		else if (addr_in == odb_pkg::ADDR_BIAS_PD)
			next_rdata = bias_reg;
		else
			next_rdata = 8'h00;
	end

	// Registered outputs so every output comes from a flip-flop
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rdata_out <= 8'h00;
			spk_unmute_out <= 1'b0;
			spk_gain_out <= 2'h0;
			dac_perf_out <= 2'h0;
			lineout_out <= 1'b0;
			sw_pd_out <= 1'b0;
			bias_level_out <= 2'h0;
			short_det_out <= 1'b0;
		end
		else
		begin
			rdata_out <= next_rdata;
			spk_unmute_out <= spk_reg[odb_pkg::SPK_UNMUTE_BIT];
			spk_gain_out <= gain_applied;
			dac_perf_out <= hp_reg[odb_pkg::HP_PERF_LO +: 2];
			lineout_out <= hp_reg[odb_pkg::HP_LINEOUT_BIT];
			sw_pd_out <= bias_reg[odb_pkg::BIAS_PD_BIT];
			bias_level_out <= bias_on ? bias_reg[odb_pkg::BIAS_LVL_LO +: 2] : 2'h0;
			short_det_out <= short_int;
		end
	end

	// Helper for the checks: cycles a gain change has been pending since the last write
	// Saturates so a stuck ramp cannot wrap back under the bound
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			ramp_age <= 4'h0;
		else if (gain_done || (wr_en_in && addr_in == odb_pkg::ADDR_SPK_CTRL))
			ramp_age <= 4'h0;
		else if (ramp_age != 4'hF)
			ramp_age <= ramp_age + 4'h1;
	end

	// Register checks
	chk_mute_follow: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		spk_unmute_out == $past(spk_reg[odb_pkg::SPK_UNMUTE_BIT]))
		else $error("speaker mute does not follow its bit");
	chk_done_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(gain_done == (spk_gain_out == spk_reg[4:3])) || $changed(gain_applied))
		else $error("gain done flag wrong");
	chk_gain_settles: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(wr_en_in && addr_in == odb_pkg::ADDR_SPK_CTRL) ##1 (!wr_en_in)[*8] |-> ##[0:8] gain_done)
		else $error("gain ramp did not settle");
	chk_perf_never_rsvd: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		hp_reg[4:3] != odb_pkg::PERF_RESERVED)
		else $error("reserved performance code stored");
	chk_lineout_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(wr_en_in && addr_in == odb_pkg::ADDR_HP_CTRL) |-> ##2 lineout_out == $past(wdata_in[2], 2))
		else $error("lineout bit not applied");
	chk_pd_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(wr_en_in && addr_in == odb_pkg::ADDR_BIAS_PD) |-> ##2 sw_pd_out == $past(wdata_in[7], 2))
		else $error("power-down bit not applied");
	chk_bias_gated: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(hs_detect_en_in && !hs_present_in && !bias_reg[3]) |=> bias_level_out == 2'h0)
		else $error("bias on without headset");
	chk_bias_level: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		bias_reg[3] |=> bias_level_out == $past(bias_reg[1:0]))
		else $error("bias level mismatch");
	chk_rsvd_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(spk_reg[1] == 1'b0) && (hp_reg[1:0] == 2'h0) && (bias_reg[6:4] == 3'h0))
		else $error("reserved bit stored nonzero");
	// Pending gain, read path, performance output and reset checks
	chk_ramp_bounded: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ramp_age <= 4'(3 * odb_pkg::GAIN_STEP_CYC))
		else $error("gain change pending too long");
	chk_done_readback: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		addr_in == odb_pkg::ADDR_SPK_CTRL |=> rdata_out[odb_pkg::SPK_DONE_BIT] == $past(gain_done))
		else $error("done flag not visible on read");
	chk_rsvd_read_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(addr_in == odb_pkg::ADDR_RSVD_2B || addr_in == odb_pkg::ADDR_RSVD_2D) |=> rdata_out == 8'h00)
		else $error("reserved register read nonzero");
	chk_perf_follow: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		dac_perf_out == $past(hp_reg[odb_pkg::HP_PERF_LO +: 2]))
		else $error("performance mode does not follow its field");
	chk_gain_step: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$changed(gain_applied) |-> $past(step_cnt) == 3'(odb_pkg::GAIN_STEP_CYC - 1))
		else $error("gain stepped early");
	chk_mute_at_reset: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(rst_n_in) |-> !spk_unmute_out)
		else $error("speaker not muted after reset");
	// Scenarios worth seeing in every run
	cov_unmute: cover property (@(posedge clk_in) $rose(spk_unmute_out));
	cov_short: cover property (@(posedge clk_in) $rose(short_det_out));
	cov_bias_gate: cover property (@(posedge clk_in) hs_detect_en_in && !hs_present_in && bias_reg[1:0] != 2'h0);
	cov_gain_ramp: cover property (@(posedge clk_in) $fell(gain_done));
	cov_osc_short: cover property (@(posedge clk_in) use_osc_in && $rose(short_det_out));
endmodule
`default_nettype wire

// ===== odb_host.sv
`default_nettype none
// Host on the register port; drives 2 ns after the rising edge
module odb_host (
	// Clock
	input wire logic clk_in,
	// Register port
	output logic wr_en_out,
	output logic [7:0] addr_out,
	output logic [7:0] wdata_out,
	input wire logic [7:0] rdata_in
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		wr_en_out = 1'b0;
		addr_out = 8'h00;
		wdata_out = 8'h00;
	end
	// Reserved bits and 0x2B only get zeros; 0x2D is never addressed
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
	begin
		@(posedge clk_in) #2;
		addr_out = a;
		wdata_out = d & (a == 8'h2A ? odb_pkg::SPK_WMASK : a == 8'h2C ? odb_pkg::HP_WMASK :
			a == 8'h2E ? odb_pkg::BIAS_WMASK : 8'h00);
		wr_en_out = 1'b1;
		@(posedge clk_in) #2;
		wr_en_out = 1'b0;
	end
	endtask
	// Read data is registered, so it is taken two edges after the address
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
	begin
		@(posedge clk_in) #2;
		addr_out = a;
		@(posedge clk_in);
		@(posedge clk_in) #2;
		d = rdata_in;
	end
	endtask
endmodule
`default_nettype wire

// ===== testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_in, rst_n_in, wr, osc, raw, den, prs, orun, otk, unm, lo, pd, sd;
	logic [1:0] gn, pf, bias;
	logic [7:0] ad, wd, rdt, got, d;
	logic [7:0] m [3];
	logic [15:0] lfsr;
	int miscompares, comparisons, n, k, c, p, cnt, ocnt;
	odb_regs odb_regs_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .wr_en_in(wr), .addr_in(ad), .wdata_in(wd),
		.rdata_out(rdt), .osc_tick_in(otk), .use_osc_in(osc), .short_raw_in(raw), .hs_detect_en_in(den),
		.hs_present_in(prs), .spk_unmute_out(unm), .spk_gain_out(gn), .dac_perf_out(pf), .lineout_out(lo),
		.sw_pd_out(pd), .bias_level_out(bias), .short_det_out(sd));
	odb_host odb_host_inst (.clk_in(clk_in), .wr_en_out(wr), .addr_out(ad), .wdata_out(wd), .rdata_in(rdt));
	// 40 MHz clock
	initial
	begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	// Oscillator unit every 10 clocks, far faster than real to keep runs short
	always @(posedge clk_in)
	begin
		#2;
		ocnt = (ocnt == 9) ? 0 : ocnt + 1;
		otk = orun && ocnt == 9;
	end
	function automatic logic [15:0] nx(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	// Bias gated off only while detection is on and no headset is in
	function automatic logic [7:0] exp_bias();
		return (m[2][3] || !den || prs) ? {6'h00, m[2][1:0]} : 8'h00;
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
	begin
		comparisons++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	end
	endtask
	task automatic give_verdict();
	begin
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
	endtask
	// Write and remember what should land
	task automatic put(input int i, input logic [7:0] v);
	begin
		m[i] = v & (i == 0 ? odb_pkg::SPK_WMASK : i == 1 ? odb_pkg::HP_WMASK : odb_pkg::BIAS_WMASK);
		odb_host_inst.wr(8'h2A + 8'(2 * i), v);
	end
	endtask
	// Long wait lets the gain ramp settle before the done flag is judged
	task automatic verify(input int i);
	begin
		repeat (20) @(posedge clk_in);
		odb_host_inst.rd(8'h2A + 8'(2 * i), got);
		check(got, m[i] | {7'h00, i == 0});
		check({unm, gn, pf, lo, pd, sd}, {m[0][2], m[0][4:3], m[1][4:3], m[1][2], m[2][7], 1'b0});
		check({6'h00, bias}, exp_bias());
	end
	endtask
	// Main sequence
	initial
	begin
		rst_n_in = 1'b0;
		{osc, raw, den, prs, orun} = 5'h00;
		lfsr = 16'h51E9;
		m = '{8'h00, 8'h00, 8'h00};
		repeat (10) @(posedge clk_in);
		#2 rst_n_in = 1'b1;
		verify(0);
		// Done flag low while the applied gain still ramps
		put(0, 8'h18);
		odb_host_inst.rd(8'h2A, got);
		check(got & 8'h01, 8'h00);
		verify(0);
		// Perf code 10 keeps the old code, the other bits still land
		put(1, 8'h08);
		odb_host_inst.wr(8'h2C, 8'h14);
		m[1] = 8'h0C;
		verify(1);
		// Reserved and unmapped places read zero
		odb_host_inst.wr(8'h2B, 8'hFF);
		odb_host_inst.rd(8'h2B, got);
		check(got, 8'h00);
		odb_host_inst.rd(8'h50, got);
		check(got, 8'h00);
		for (n = 0; n < 40; n++)
		begin
			lfsr = nx(lfsr);
			k = int'(lfsr[1:0]) % 3;
			d = lfsr[15:8];
			if (k == 1 && d[4:3] == 2'h2)
				d[3] = 1'b1;
			den = lfsr[2];
			prs = lfsr[3];
			put(k, d);
			verify(k);
		end
		// Mid-run reset returns every register to its reset value
		rst_n_in = 1'b0;
		m = '{8'h00, 8'h00, 8'h00};
		repeat (2) @(posedge clk_in);
		#2 rst_n_in = 1'b1;
		verify(1);
		verify(2);
		// Debounce for every code on the clock timebase, then code 2 on the oscillator
		for (c = 0; c < 9; c++)
		begin
			osc = (c == 8);
			orun = (c == 8);
			put(1, {c == 8 ? 3'h2 : c[2:0], 5'h00});
			repeat (20) @(posedge clk_in);
			#2 raw = 1'b1;
			p = (c == 8) ? 20 : (c == 0) ? 0 : odb_pkg::TICK_CYC << (c - 1);
			for (cnt = 0; sd !== 1'b1 && cnt < 30000; cnt++)
				@(posedge clk_in) #2;
			check({7'h00, cnt > 7 * p && cnt <= 9 * p + (c == 8 ? 12 : 3)}, 8'h01);
			if (cnt == 30000)
				give_verdict();
			raw = 1'b0;
			repeat (3) @(posedge clk_in);
			#2 check({7'h00, sd}, 8'h00);
		end
		give_verdict();
	end
endmodule
`default_nettype wire
